/* File: rtl/tbs_pkg.sv */
package tbs_pkg;
   // Event sources for each layer
   typedef enum logic [2:0] {
      TBS_SRC_IMMEDIATE,
      TBS_SRC_EXTERNAL,
      TBS_SRC_TIMER,
      TBS_SRC_MANUAL,
      TBS_SRC_BUS,
      TBS_SRC_HOLD
   } tbs_src_t;
   localparam int TBS_LINES = 6;
   localparam int TBS_LINE_W = 3;
   localparam int TBS_CNT_W = 20;
   // Count value meaning run forever
   localparam logic [TBS_CNT_W-1:0] TBS_CNT_INF = 20'h0_0000;
   localparam logic [TBS_CNT_W-1:0] TBS_CNT_ONE = 20'h0_0001;
   localparam logic [TBS_LINE_W-1:0] TBS_LINE_IN_RST = 3'h0;
   localparam logic [TBS_LINE_W-1:0] TBS_LINE_OUT_RST = 3'h1;
   localparam int TBS_PULSE_W = 8;
   localparam logic [TBS_PULSE_W-1:0] TBS_PULSE_RST = 8'h0a;
   localparam int TBS_DLY_W = 16;
   localparam logic [TBS_DLY_W-1:0] TBS_SETTLE_RST = 16'h0004;
   localparam logic [TBS_DLY_W-1:0] TBS_DLY_RST = 16'h0000;
   // Register byte offsets
   localparam int TBS_AW = 5;
   localparam logic [TBS_AW-1:0] TBS_REG_CTRL = 5'h00;
   localparam logic [TBS_AW-1:0] TBS_REG_ARM = 5'h04;
   localparam logic [TBS_AW-1:0] TBS_REG_SCAN = 5'h08;
   localparam logic [TBS_AW-1:0] TBS_REG_MEAS = 5'h0c;
   localparam logic [TBS_AW-1:0] TBS_REG_DLY = 5'h10;
   localparam logic [TBS_AW-1:0] TBS_REG_STAT = 5'h14;
   // Field positions inside a layer register
   localparam int TBS_F_SRC = 0;
   localparam int TBS_F_BYP = 3;
   localparam int TBS_F_IN = 4;
   localparam int TBS_F_OUT = 8;
   localparam int TBS_F_CNT = 12;
   // Field positions inside control register
   localparam int TBS_F_CONT = 0;
   localparam int TBS_F_SPLIT = 1;
   localparam int TBS_F_INIT = 2;
   localparam int TBS_F_HALT = 3;
   localparam int TBS_F_MANU = 4;
   localparam int TBS_F_PW = 8;
   localparam int TBS_F_SETTLE = 16;
endpackage

/* File: rtl/tbs_edge.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser and falling edge detector
module tbs_edge
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_line,
   output logic o_fall
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end
      else
      begin
         s1_q <= i_line;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign o_fall = s3_q & ~s2_q;
endmodule // tbs_edge
`default_nettype wire

/* File: rtl/tbs_top.sv */
// Behaviour
// - One completion pulse after each measurement for external, timer, manual, immediate sources.
// - Completion waits for settling interval plus programmed delay.
// - Scan bypass with external source outputs a trigger on each scan return.
// - Arm bypass with external source outputs a trigger on each arm return.
// - Six individually selectable bus trigger lines.
// - Split-line mode uses two lines; shared mode uses one line.
// - Split-line bus pulses match the external input and completion pulses.
// - Split-line configuration with identical input and output line is rejected.
// - Measure layer answers bus triggers only with bus source selected.
// - Each bus trigger starts one measurement, ended by a pulse on output line.
// - Scan and arm layers have own bus line selections, may equal measure.
// - Reset loads continuous on, immediate arm and scan sources, external measure source, counts, bypass off.
// - Immediate arm and scan pass straight to waiting in measure layer.
// - Each trigger takes a reading, stores it, then sends output pulse.
// - External input recognised on its falling edge.
// - Bypass skips a layer's event on the first pass only.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tbs_top
   import tbs_pkg::*;
#(
   parameter int LINES = TBS_LINES
)
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic [TBS_AW-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_ext_trigger_in,
   output logic o_completion_out_n,
   input wire logic [LINES-1:0] i_bus_line,
   output logic [LINES-1:0] o_bus_line,
   output logic [LINES-1:0] o_bus_line_oe,
   output logic o_meas_start,
   input wire logic i_meas_done,
   output logic o_store,
   output logic o_idle,
   output logic o_cfg_err
);
   typedef enum {ST_IDLE, ST_ARM, ST_SCAN, ST_MEAS, ST_CONV, ST_SETTLE, ST_PULSE}
      tbs_state_t;
   tbs_state_t st_q;
   logic cont_q, split_q, manu_q, init_q, halt_q;
   logic [TBS_PULSE_W-1:0] pw_q;
   logic [TBS_DLY_W-1:0] settle_q, dly_q;
   logic [31:0] arm_q, scan_q, meas_q;
   logic [TBS_CNT_W-1:0] arm_n_q, scan_n_q, meas_n_q;
   logic arm_first_q, scan_first_q;
   logic [TBS_DLY_W:0] tmr_q;
   logic [TBS_PULSE_W-1:0] pcnt_q;
   logic [LINES-1:0] pline_q;
   logic pext_q;
   logic ext_fall;
   logic [LINES-1:0] bus_fall;
   logic bad_cfg;
   tbs_edge u_ext
   (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_line(i_ext_trigger_in),
      .o_fall(ext_fall)
   );
   genvar g;
   generate
      for (g = 0; g < LINES; g++)
      begin : g_line
         // Read back our own drive too; a driven low is masked below
         tbs_edge u_bus
         (
            .i_core_clk(i_core_clk),
            .i_rstn(i_rstn),
            .i_line(i_bus_line[g]),
            .o_fall(bus_fall[g])
         );
      end
   endgenerate
   function automatic tbs_src_t src_of(input logic [31:0] r);
      src_of = tbs_src_t'(r[TBS_F_SRC +: 3]);
   endfunction
   function automatic logic [TBS_LINE_W-1:0] lin(input logic [31:0] r);
      lin = r[TBS_F_IN +: TBS_LINE_W];
   endfunction
   function automatic logic [TBS_LINE_W-1:0] lout(input logic [31:0] r);
      // Shared mode drives the input line itself
      lout = split_q ? r[TBS_F_OUT +: TBS_LINE_W] : r[TBS_F_IN +: TBS_LINE_W];
   endfunction
   function automatic logic same_line(input logic [31:0] r);
      same_line = r[TBS_F_IN +: TBS_LINE_W] == r[TBS_F_OUT +: TBS_LINE_W];
   endfunction
   // Event seen by a layer for its programmed source
   function automatic logic layer_evt(input logic [31:0] r);
      logic [TBS_LINE_W-1:0] li;
      li = lin(r);
      case (src_of(r))
         TBS_SRC_IMMEDIATE: layer_evt = 1'b1;
         TBS_SRC_EXTERNAL: layer_evt = ext_fall | manu_q;
         TBS_SRC_TIMER: layer_evt = 1'b1;
         TBS_SRC_MANUAL: layer_evt = manu_q;
         TBS_SRC_BUS: layer_evt = (li < LINES) && bus_fall[li] && pcnt_q == '0;
         default: layer_evt = 1'b0;
      endcase
   endfunction
   // Split-line with one line for both is refused
   assign bad_cfg = split_q && ((src_of(meas_q) == TBS_SRC_BUS && same_line(meas_q))
                  || (src_of(scan_q) == TBS_SRC_BUS && same_line(scan_q))
                  || (src_of(arm_q) == TBS_SRC_BUS && same_line(arm_q)));
   // Register file
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cont_q <= 1'b1;
         split_q <= 1'b1;
         pw_q <= TBS_PULSE_RST;
         settle_q <= TBS_SETTLE_RST;
         dly_q <= TBS_DLY_RST;
         arm_q <= {TBS_CNT_ONE, 1'b0, TBS_LINE_OUT_RST, 1'b0, TBS_LINE_IN_RST, 1'b0,
                   TBS_SRC_IMMEDIATE};
         scan_q <= {TBS_CNT_INF, 1'b0, TBS_LINE_OUT_RST, 1'b0, TBS_LINE_IN_RST, 1'b0,
                    TBS_SRC_IMMEDIATE};
         meas_q <= {TBS_CNT_INF, 1'b0, TBS_LINE_OUT_RST, 1'b0, TBS_LINE_IN_RST, 1'b0,
                    TBS_SRC_EXTERNAL};
      end
      else if (i_wr)
      begin
         case (i_addr)
            TBS_REG_CTRL:
            begin
               cont_q <= i_wdata[TBS_F_CONT];
               split_q <= i_wdata[TBS_F_SPLIT];
               pw_q <= i_wdata[TBS_F_PW +: TBS_PULSE_W];
               settle_q <= i_wdata[TBS_F_SETTLE +: TBS_DLY_W];
            end
            TBS_REG_ARM: arm_q <= i_wdata;
            TBS_REG_SCAN: scan_q <= i_wdata;
            TBS_REG_MEAS: meas_q <= i_wdata;
            TBS_REG_DLY: dly_q <= i_wdata[TBS_DLY_W-1:0];
            default: ;
         endcase
      end
   end
   // Command strobes, one cycle
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         init_q <= 1'b0;
         halt_q <= 1'b0;
         manu_q <= 1'b0;
      end
      else
      begin
         init_q <= i_wr && i_addr == TBS_REG_CTRL && i_wdata[TBS_F_INIT];
         halt_q <= i_wr && i_addr == TBS_REG_CTRL && i_wdata[TBS_F_HALT];
         manu_q <= i_wr && i_addr == TBS_REG_CTRL && i_wdata[TBS_F_MANU];
      end
   end
   // Read port
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         o_rdata <= '0;
      else if (i_rd)
      begin
         case (i_addr)
            TBS_REG_CTRL: o_rdata <= {settle_q, pw_q, 6'h00, split_q, cont_q};
            TBS_REG_ARM: o_rdata <= arm_q;
            TBS_REG_SCAN: o_rdata <= scan_q;
            TBS_REG_MEAS: o_rdata <= meas_q;
            TBS_REG_DLY: o_rdata <= {16'h0000, dly_q};
            TBS_REG_STAT: o_rdata <= {26'h000_0000, bad_cfg, 1'b0, 3'(st_q), o_idle};
            default: o_rdata <= 32'h0000_0000;
         endcase
      end
      else
         o_rdata <= '0;
   end
   // Trigger model sequencer
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_q <= ST_ARM;
         arm_n_q <= '0;
         scan_n_q <= '0;
         meas_n_q <= '0;
         arm_first_q <= 1'b1;
         scan_first_q <= 1'b1;
         tmr_q <= '0;
         pcnt_q <= '0;
         pline_q <= '0;
         pext_q <= 1'b0;
         o_meas_start <= 1'b0;
         o_store <= 1'b0;
         o_idle <= 1'b0;
         o_cfg_err <= 1'b0;
      end
      else
      begin
         o_meas_start <= 1'b0;
         o_store <= 1'b0;
         o_cfg_err <= bad_cfg;
         if (pcnt_q != '0)
            pcnt_q <= pcnt_q - 1'b1;
         // Drop the drive on the last counted cycle so the pulse is exactly pw_q long
         if (pcnt_q <= TBS_PULSE_W'(1))
         begin
            pline_q <= '0;
            pext_q <= 1'b0;
         end
         if (halt_q)
         begin
            st_q <= ST_IDLE;
            o_idle <= 1'b1;
         end
         else
         begin
            case (st_q)
               ST_IDLE:
                  if (init_q || cont_q)
                  begin
                     st_q <= ST_ARM;
                     o_idle <= 1'b0;
                     arm_first_q <= 1'b1;
                     arm_n_q <= '0;
                  end
               ST_ARM:
                  if (!bad_cfg && ((arm_first_q && arm_q[TBS_F_BYP]) || layer_evt(arm_q)))
                  begin
                     st_q <= ST_SCAN;
                     arm_first_q <= 1'b0;
                     scan_first_q <= 1'b1;
                     scan_n_q <= '0;
                  end
               ST_SCAN:
                  if (!bad_cfg && ((scan_first_q && scan_q[TBS_F_BYP]) || layer_evt(scan_q)))
                  begin
                     st_q <= ST_MEAS;
                     scan_first_q <= 1'b0;
                     meas_n_q <= '0;
                  end
               ST_MEAS:
                  if (!bad_cfg && ((meas_n_q == '0 && meas_q[TBS_F_BYP]) || layer_evt(meas_q)))
                  begin
                     st_q <= ST_CONV;
                     o_meas_start <= 1'b1;
                  end
               ST_CONV:
                  if (i_meas_done)
                  begin
                     st_q <= ST_SETTLE;
                     o_store <= 1'b1;
                     tmr_q <= TBS_DLY_W'(settle_q) + TBS_DLY_W'(dly_q) + 1'b1;
                  end
               ST_SETTLE:
                  if (tmr_q <= 1)
                  begin
                     st_q <= ST_PULSE;
                  end
                  else
                     tmr_q <= tmr_q - 1'b1;
               ST_PULSE:
               begin
                  // Completion on external pin or the measure output line
                  pcnt_q <= pw_q;
                  if (src_of(meas_q) == TBS_SRC_BUS)
                     pline_q <= LINES'(1) << lout(meas_q);
                  else
                     pext_q <= 1'b1;
                  meas_n_q <= meas_n_q + 1'b1;
                  if (meas_q[TBS_F_CNT +: TBS_CNT_W] == TBS_CNT_INF
                      || meas_n_q + 1'b1 < meas_q[TBS_F_CNT +: TBS_CNT_W])
                     st_q <= ST_MEAS;
                  else if (scan_q[TBS_F_CNT +: TBS_CNT_W] == TBS_CNT_INF
                           || scan_n_q + 1'b1 < scan_q[TBS_F_CNT +: TBS_CNT_W])
                  begin
                     st_q <= ST_SCAN;
                     scan_n_q <= scan_n_q + 1'b1;
                     if (scan_q[TBS_F_BYP] && src_of(scan_q) == TBS_SRC_EXTERNAL)
                        pext_q <= 1'b1;
                  end
                  else if (arm_q[TBS_F_CNT +: TBS_CNT_W] == TBS_CNT_INF
                           || arm_n_q + 1'b1 < arm_q[TBS_F_CNT +: TBS_CNT_W])
                  begin
                     st_q <= ST_ARM;
                     arm_n_q <= arm_n_q + 1'b1;
                     if (arm_q[TBS_F_BYP] && src_of(arm_q) == TBS_SRC_EXTERNAL)
                        pext_q <= 1'b1;
                  end
                  else
                  begin
                     st_q <= ST_IDLE;
                     o_idle <= !cont_q;
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end
   // Active-low completion drive and open-drain bus line drive
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_completion_out_n <= 1'b1;
         o_bus_line <= '0;
         o_bus_line_oe <= '0;
      end
      else
      begin
         o_completion_out_n <= ~pext_q;
         o_bus_line <= '0;
         o_bus_line_oe <= pline_q;
      end
   end
endmodule // tbs_top
`default_nettype wire

/* File: tb/tbs_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tbs_props
   import tbs_pkg::*;
#(
   parameter int LINES = TBS_LINES
)
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic [TBS_AW-1:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_meas_done,
   input wire logic o_completion_out_n,
   input wire logic [LINES-1:0] o_bus_line,
   input wire logic [LINES-1:0] o_bus_line_oe,
   input wire logic o_store,
   input wire logic o_meas_start,
   input wire logic o_cfg_err
);
   logic [15:0] dly_q;
   logic [17:0] since_q;
   logic [8:0] low_q, oe_q;
   logic pend_q;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rstn);
   // Width and settle are left at reset values by the bench; only delay is shadowed
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         dly_q <= TBS_DLY_RST;
         since_q <= 18'h0_0000;
         low_q <= 9'h000;
         oe_q <= 9'h000;
         pend_q <= 1'b0;
      end
      else
      begin
         if (i_wr && i_addr == TBS_REG_DLY)
            dly_q <= i_wdata[15:0];
         since_q <= i_meas_done ? 18'h0_0000 : since_q + 18'(since_q != 18'h3_ffff);
         low_q <= o_completion_out_n ? 9'h000 : low_q + 9'h001;
         oe_q <= (|o_bus_line_oe) ? oe_q + 9'h001 : 9'h000;
         pend_q <= o_store | (pend_q & o_completion_out_n & ~(|o_bus_line_oe));
      end
   end
   a_out_after_store: assert property (
      o_store |-> ##[1:1000] (!o_completion_out_n || (|o_bus_line_oe)))
      else $error("no pulse after store");
   a_store_after_done: assert property (
      $rose(o_store) |-> $past(i_meas_done) || $past(i_meas_done, 2))
      else $error("store without done");
   a_pulse_width: assert property (
      $rose(o_completion_out_n) |-> low_q == 9'(TBS_PULSE_RST))
      else $error("completion width wrong");
   a_oe_width: assert property (
      $fell(|o_bus_line_oe) |-> oe_q == 9'(TBS_PULSE_RST))
      else $error("bus pulse width wrong");
   a_settle_delay: assert property (
      ($fell(o_completion_out_n) || $rose(|o_bus_line_oe)) && pend_q
      |-> since_q >= 18'(TBS_SETTLE_RST) + 18'(dly_q))
      else $error("pulse before settle and delay");
   a_cfg_blocks: assert property (o_cfg_err |-> !o_meas_start)
      else $error("start with bad config");
   a_one_line: assert property ($onehot0(o_bus_line_oe))
      else $error("several lines driven");
   a_drive_low: assert property (o_bus_line == '0)
      else $error("bus line driven high");
   c_ext: cover property ($rose(o_completion_out_n));
   c_bus: cover property ($fell(|o_bus_line_oe));
   c_err: cover property (o_cfg_err);
endmodule // tbs_props
bind tbs_top tbs_props #(.LINES(LINES)) u_props
(
   .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_meas_done(i_meas_done), .o_completion_out_n(o_completion_out_n), .o_bus_line(o_bus_line),
   .o_bus_line_oe(o_bus_line_oe), .o_store(o_store), .o_meas_start(o_meas_start),
   .o_cfg_err(o_cfg_err)
);
`default_nettype wire

/* File: tb/tbs_scanner.sv */
`timescale 1ns/1ps
`default_nettype none
// Far-side scanner: settles a channel, then sends one trigger pulse
module tbs_scanner
#(
   parameter int SETTLE = 6,
   parameter int PW = 4
)
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_go,
   input wire logic i_en,
   input wire logic i_use_bus,
   input wire logic [2:0] i_drv,
   input wire logic [2:0] i_lsn,
   input wire logic i_cmp_n,
   input wire logic [5:0] i_wire,
   output logic o_ext_n,
   output logic [5:0] o_pull
);
   int wait_q;
   int pw_q;
   logic lsn_q;
   wire logic lsn = i_use_bus ? i_wire[i_lsn] : i_cmp_n;
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         lsn_q <= 1'b1;
         wait_q <= 0;
         pw_q <= 0;
      end
      else
      begin
         lsn_q <= lsn;
         // Own pulse on a shared line is not taken as a request
         if ((i_go || (i_en && lsn_q && !lsn)) && pw_q == 0 && wait_q == 0)
            wait_q <= SETTLE;
         else if (wait_q > 1 || (wait_q == 1 && lsn))
            wait_q <= wait_q - 1;
         // A shared line must be released by the device before we pull it again
         if (wait_q == 1 && lsn)
            pw_q <= PW;
         else if (pw_q > 0)
            pw_q <= pw_q - 1;
      end
   end
   assign o_ext_n = !(pw_q > 0 && !i_use_bus);
   assign o_pull = (pw_q > 0 && i_use_bus) ? 6'h01 << i_drv : 6'h00;
endmodule // tbs_scanner
`default_nettype wire

/* File: tb/tb_trigger_bus_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_trigger_bus_sequencer;
   import tbs_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0, rd = 1'b0, done = 1'b0, go = 1'b0, en = 1'b0, bus = 1'b0, cmp_q = 1'b1;
   logic [2:0] drv = 3'h0, lsn = 3'h0, cv = 3'h0;
   logic [31:0] rdata;
   logic ext_n, cmp_n, start, store, idle, cfg_err;
   logic [5:0] oe, lvl, pull, bl, oe_q = 6'h00;
   int n_fail = 0, num_checks = 0, n_start = 0, n_store = 0, n_cmp = 0, cyc = 0;
   int n_oe [6] = '{default: 0};
   always #20 clk = ~clk;
   assign lvl = ~(oe | pull);
   tbs_top DUT
   (
      .i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_ext_trigger_in(ext_n), .o_completion_out_n(cmp_n), .i_bus_line(lvl),
      .o_bus_line(bl), .o_bus_line_oe(oe), .o_meas_start(start), .i_meas_done(done),
      .o_store(store), .o_idle(idle), .o_cfg_err(cfg_err)
   );
   tbs_scanner u_scn
   (
      .i_core_clk(clk), .i_rstn(rstn), .i_go(go), .i_en(en), .i_use_bus(bus), .i_drv(drv),
      .i_lsn(lsn), .i_cmp_n(cmp_n), .i_wire(lvl), .o_ext_n(ext_n), .o_pull(pull)
   );
   // Converter answers four cycles after each start; monitor counts events
   always @(posedge clk)
   begin
      cv <= {cv[1:0], start};
      done <= cv[2];
      cmp_q <= cmp_n;
      oe_q <= oe;
      n_start += start;
      n_store += store;
      n_cmp += (cmp_q & ~cmp_n);
      for (int i = 0; i < 6; i++)
         n_oe[i] += (oe[i] & ~oe_q[i]);
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         end_sim();
      end
   end
   task automatic end_sim;
      if (n_fail == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(nm, e, rdata);
      @(posedge clk);
   endtask
   function automatic logic [31:0] lay(logic [19:0] c, logic [2:0] o, logic [2:0] i,
                                       logic [3:0] s);
      return {c, 1'b0, o, 1'b0, i, s};
   endfunction
   task automatic run(input int n, input logic b, input logic [2:0] d, input logic [2:0] l);
      n_start = 0;
      n_store = 0;
      n_cmp = 0;
      n_oe = '{default: 0};
      bus <= b;
      drv <= d;
      lsn <= l;
      en <= 1'b1;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (int k = 0; k < 3000 && (b ? n_oe[l] : n_cmp) < n; k++)
      begin
         if (n_start >= n)
            en <= 1'b0;
         @(posedge clk);
      end
      en <= 1'b0;
      repeat (30) @(posedge clk);
      chk("starts", n, n_start);
      chk("stores", n, n_store);
      chk("pulses", n, b ? n_oe[l] : n_cmp);
   endtask
   task automatic s_reset;
      logic [2:0] o = TBS_LINE_OUT_RST;
      logic [2:0] i = TBS_LINE_IN_RST;
      rd_chk("ctrl", TBS_REG_CTRL, {TBS_SETTLE_RST, TBS_PULSE_RST, 8'h03});
      rd_chk("arm", TBS_REG_ARM, lay(TBS_CNT_ONE, o, i, 4'h0));
      rd_chk("scan", TBS_REG_SCAN, lay(TBS_CNT_INF, o, i, 4'h0));
      rd_chk("meas", TBS_REG_MEAS, lay(TBS_CNT_INF, o, i, 4'h1));
      rd_chk("unmapped", 5'h1c, 32'h0000_0000);
      chk("idle", 32'h0000_0000, idle);
   endtask
   task automatic s_ext;
      wr_reg(TBS_REG_DLY, 32'h0000_0005);
      run(3, 1'b0, 3'h0, 3'h0);
   endtask
   task automatic s_manual;
      wr_reg(TBS_REG_MEAS, lay(TBS_CNT_INF, 3'h1, 3'h0, {1'b0, TBS_SRC_MANUAL}));
      n_cmp = 0;
      wr_reg(TBS_REG_CTRL, {TBS_SETTLE_RST, TBS_PULSE_RST, 8'h13});
      for (int k = 0; k < 300 && n_cmp < 1; k++)
         @(posedge clk);
      repeat (40) @(posedge clk);
      chk("manual", 1, n_cmp);
   endtask
   task automatic s_bus;
      logic [2:0] ln [8] = '{3'h0, 3'h5, 3'h5, 3'h0, 3'h2, 3'h3, 3'h1, 3'h4};
      for (int p = 0; p < 8; p += 2)
      begin
         wr_reg(TBS_REG_MEAS, lay(TBS_CNT_INF, ln[p+1], ln[p], {1'b0, TBS_SRC_BUS}));
         run(2, 1'b1, ln[p], ln[p+1]);
      end
   endtask
   task automatic s_quiet(input logic [31:0] m, input logic e);
      wr_reg(TBS_REG_MEAS, m);
      #1 chk("cfg_err", e, cfg_err);
      n_start = 0;
      bus <= 1'b1;
      drv <= 3'h2;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (40) @(posedge clk);
      chk("ignored", 0, n_start);
   endtask
   task automatic s_shared;
      wr_reg(TBS_REG_CTRL, {TBS_SETTLE_RST, TBS_PULSE_RST, 8'h01});
      wr_reg(TBS_REG_MEAS, lay(TBS_CNT_INF, 3'h4, 3'h4, {1'b0, TBS_SRC_BUS}));
      run(3, 1'b1, 3'h4, 3'h4);
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      s_reset();
      s_ext();
      s_manual();
      s_bus();
      s_quiet(lay(TBS_CNT_INF, 3'h2, 3'h2, {1'b0, TBS_SRC_BUS}), 1'b1);
      s_quiet(lay(TBS_CNT_INF, 3'h3, 3'h2, {1'b0, TBS_SRC_EXTERNAL}), 1'b0);
      s_shared();
      end_sim();
   end
endmodule // tb_trigger_bus_sequencer
`default_nettype wire
